/* File: pkg/wdtu_pkg.sv */
// Functional notes
// - 22-bit counter advances each machine cycle when enabled
// - Machine cycle equals twelve oscillator periods
// - Counter overflow asserts internal processor reset
// - Reload value loads seven counter MSBs
// - Writing zero to reload clears counter
// - Only key 0x55 disables the watchdog
// - Watchdog enabled after any reset
// - Keeps counting and resetting in Idle
// - Reset pulse lasts 12 times 2^15 periods
// - Common reset also driven out active low
`default_nettype none
package wdtu_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] WDTU_ADDR_RELOAD = 8'ha6;
	localparam logic [7:0] WDTU_ADDR_KEY    = 8'hae;
	localparam logic [7:0] WDTU_KEY_DISABLE = 8'h55;
	localparam logic [7:0] WDTU_KEY_RESET   = 8'h00;
	localparam int         WDTU_RELOAD_MSB  = 6;
	localparam int         WDTU_KEY_MSB     = 7;
	// ****************************************
	// Timing
	// ****************************************
	localparam int WDTU_CNT_WIDTH     = 22;
	localparam int WDTU_RELOAD_WIDTH  = 7;
	localparam int WDTU_OSC_PER_MC    = 12;
	localparam int WDTU_PULSE_MC      = 32768;
	localparam int WDTU_PULSE_CYCLES  = WDTU_OSC_PER_MC * WDTU_PULSE_MC;
	localparam int WDTU_CLK_PERIOD_NS = 10;
endpackage
`default_nettype wire

/* File: verilog/wdtu_prescaler.sv */
`default_nettype none
module wdtu_prescaler
	import wdtu_pkg::*;
#(
	parameter int DIV = WDTU_OSC_PER_MC
) (
	input  wire logic MCLK_I,
	input  wire logic RST_I,
	output logic      tick_o
);
	localparam int W = $clog2(DIV);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tick;

	initial begin
		if (DIV < 2) $error("DIV too small");
	end

	always_comb begin
		next_tick = (cnt == W'(DIV - 1));
		next_cnt  = next_tick ? '0 : cnt + 1'b1;
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule // wdtu_prescaler
`default_nettype wire

/* File: verilog/wdtu_watchdog.sv */
`default_nettype none
module wdtu_watchdog
	import wdtu_pkg::*;
#(
	parameter int PULSE_CYCLES = WDTU_PULSE_CYCLES,
	parameter int CNT_WIDTH    = WDTU_CNT_WIDTH
) (
	// Clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       RST_I,
	// Special function register port
	input  wire logic [7:0] SFR_ADDR_I,
	input  wire logic [7:0] SFR_WDATA_I,
	input  wire logic       SFR_WR_I,
	input  wire logic       SFR_RD_I,
	output logic      [7:0] SFR_RDATA_O,
	// Reset outputs
	output logic            GUARD_RST_O,
	output logic            SYS_RESET_N_O
);

	// ****************************************
	// Elaboration checks
	// ****************************************

	localparam int PW = $clog2(PULSE_CYCLES + 1);

	// A counter no wider than the reload field leaves nothing to count
	initial begin
		if (PULSE_CYCLES < 1) begin
			$error("PULSE_CYCLES must be positive");
		end
		if (CNT_WIDTH <= WDTU_RELOAD_WIDTH) begin
			$error("CNT_WIDTH must exceed the reload field");
		end
	end

	// ****************************************
	// Helper functions
	// ****************************************

	// Address match, shared by the write and read decoders
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return (addr == target);
	endfunction

	// Reload value lands in the top bits, all lower bits cleared
	function automatic logic [CNT_WIDTH-1:0] reload_word(
		input logic [7:0] data
	);
		logic [CNT_WIDTH-1:0] word;
		word = '0;
		word[CNT_WIDTH-1 -: WDTU_RELOAD_WIDTH] = data[WDTU_RELOAD_MSB:0];
		return word;
	endfunction

	// Only the one exact pattern stops the counter
	function automatic logic key_open(
		input logic [7:0] key
	);
		return (key != WDTU_KEY_DISABLE);
	endfunction

	// ****************************************
	// Declarations
	// ****************************************

	logic                 mc_tick;
	logic [CNT_WIDTH-1:0] overflow_guard_counter;
	logic [CNT_WIDTH-1:0] next_counter;
	logic [7:0]           guard_key_reg;
	logic [7:0]           next_key;
	logic [PW-1:0]        pulse_cnt;
	logic [PW-1:0]        next_pulse_cnt;
	logic                 next_guard_rst;
	logic                 next_sys_reset_n;
	logic [7:0]           next_rdata;
	logic                 enabled;
	logic                 wr_reload;
	logic                 wr_key;
	logic                 rd_key;
	logic                 overflow;
	logic                 pulse_busy;

	// ****************************************
	// Machine cycle strobe
	// ****************************************

	wdtu_prescaler #(
		.DIV (WDTU_OSC_PER_MC)
	) u_presc (
		.MCLK_I (MCLK_I),
		.RST_I  (RST_I),
		.tick_o (mc_tick)
	);

	// ****************************************
	// Access decode
	// ****************************************

	// Accesses during the pulse are dropped: the core is held in reset then
	always_comb begin
		pulse_busy = GUARD_RST_O;
		wr_reload  = SFR_WR_I && !pulse_busy && addr_hit(SFR_ADDR_I, WDTU_ADDR_RELOAD);
		wr_key     = SFR_WR_I && !pulse_busy && addr_hit(SFR_ADDR_I, WDTU_ADDR_KEY);
		rd_key     = SFR_RD_I && !pulse_busy && addr_hit(SFR_ADDR_I, WDTU_ADDR_KEY);
		enabled    = key_open(guard_key_reg);
		overflow   = enabled && mc_tick && (&overflow_guard_counter);
	end

	// ****************************************
	// Counter
	// ****************************************

	always_comb begin
		next_counter = overflow_guard_counter;
		if (pulse_busy) begin
			next_counter = '0;
		end else if (wr_reload) begin
			// Service wins over a same-cycle increment; zero clears all bits
			next_counter = reload_word(SFR_WDATA_I);
		end else if (enabled && mc_tick) begin
			// Runs regardless of Idle: the oscillator never stops there
			next_counter = overflow_guard_counter + 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			overflow_guard_counter <= '0;
		end else begin
			overflow_guard_counter <= next_counter;
		end
	end

	// ****************************************
	// Key
	// ****************************************

	// The pulse puts the key back, so the watchdog comes out of it enabled
	always_comb begin
		next_key = guard_key_reg;
		if (pulse_busy) begin
			next_key = WDTU_KEY_RESET;
		end else if (wr_key) begin
			next_key = SFR_WDATA_I;
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			guard_key_reg <= WDTU_KEY_RESET;
		end else begin
			guard_key_reg <= next_key;
		end
	end

	// ****************************************
	// Reset pulse
	// ****************************************

	// The count length trades a long counter for an exact pulse width
	always_comb begin
		next_pulse_cnt = pulse_cnt;
		if (overflow) begin
			next_pulse_cnt = PW'(PULSE_CYCLES);
		end else if (pulse_cnt != '0) begin
			next_pulse_cnt = pulse_cnt - 1'b1;
		end
		next_guard_rst   = (next_pulse_cnt != '0);
		next_sys_reset_n = !next_guard_rst;
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			pulse_cnt     <= '0;
			GUARD_RST_O   <= 1'b0;
			SYS_RESET_N_O <= 1'b0;
		end else begin
			pulse_cnt     <= next_pulse_cnt;
			GUARD_RST_O   <= next_guard_rst;
			SYS_RESET_N_O <= next_sys_reset_n;
		end
	end

	// ****************************************
	// Read port
	// ****************************************

	// Only the key reads back; the reload register is write-only
	always_comb begin
		next_rdata = 8'h00;
		if (rd_key) begin
			next_rdata = guard_key_reg;
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			SFR_RDATA_O <= 8'h00;
		end else begin
			SFR_RDATA_O <= next_rdata;
		end
	end

	// ****************************************
	// Usage limits
	// ****************************************

	// The reload field takes only values up to 0x7f; bit 7 is dropped.
	// A reload written in the cycle of an overflow still loses to the
	// pulse, so service well before the counter runs out.
	// Disabling with the key freezes the counter at its present value;
	// any other key value lets it continue from there.
	// The prescaler is free running, so the first machine cycle after a
	// reload may come anywhere from one to twelve clocks later.
	// During the pulse the read port answers zero and writes are lost.
	// The active-low reset out follows the pulse with no extra delay,
	// and it is low while the system reset input is held.

endmodule // wdtu_watchdog
`default_nettype wire

/* File: tb/wdtu_properties.sv */
`default_nettype none
// ****
// Port checks
// ****
module wdtu_properties #(parameter int PULSE_CYCLES = 20) (
	input wire logic MCLK_I, RST_I, SFR_WR_I, SFR_RD_I, GUARD_RST_O, SYS_RESET_N_O,
	input wire logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O);
	localparam int PULSE_LAST = PULSE_CYCLES;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	sequence s_kw; SFR_WR_I && SFR_ADDR_I == 8'hae && !GUARD_RST_O; endsequence
	sequence s_kr; SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == 8'hae && !GUARD_RST_O; endsequence
	property p_rstn; !$past(RST_I) |-> SYS_RESET_N_O != GUARD_RST_O; endproperty
	a_rstn: assert property (p_rstn) else $error("reset out");
	property p_key; s_kw ##1 s_kr |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2); endproperty
	a_key: assert property (p_key) else $error("key read");
	property p_idle; !SFR_RD_I |=> SFR_RDATA_O == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_unm; SFR_RD_I && SFR_ADDR_I != 8'hae |=> SFR_RDATA_O == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_len; $rose(GUARD_RST_O) |-> GUARD_RST_O [*8]; endproperty
	a_len: assert property (p_len) else $error("pulse short");
	property p_end; $rose(GUARD_RST_O) |-> ##PULSE_LAST !GUARD_RST_O; endproperty
	a_end: assert property (p_end) else $error("pulse long");
	property p_start; $past(RST_I) |-> !GUARD_RST_O; endproperty
	a_start: assert property (p_start) else $error("start");
	property p_busy; GUARD_RST_O && SFR_RD_I |=> SFR_RDATA_O == 8'h00; endproperty
	a_busy: assert property (p_busy) else $error("busy read");
	property p_fall; $rose(GUARD_RST_O) |-> $fell(SYS_RESET_N_O); endproperty
	a_fall: assert property (p_fall) else $error("fall");
endmodule // wdtu_properties
bind wdtu_watchdog wdtu_properties #(.PULSE_CYCLES(PULSE_CYCLES)) wdtu_properties_i (
	.MCLK_I(MCLK_I), .RST_I(RST_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
	.GUARD_RST_O(GUARD_RST_O), .SYS_RESET_N_O(SYS_RESET_N_O),
	.SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O));
`default_nettype wire

/* File: tb/test_watchdog_timer_unit.sv */
`default_nettype none
module test_watchdog_timer_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rst = 1, wr = 0, rd = 0;
	logic [7:0] adr = 8'h00, wd = 8'h00, q;
	wire logic [7:0] rdat;
	wire logic       wres, sysn;
	int error_cnt = 0, checks_done = 0;
	// A short counter lets an overflow happen within the run
	wdtu_watchdog #(.PULSE_CYCLES(20), .CNT_WIDTH(10)) wdtu_watchdog_i (.MCLK_I(clk),
		.RST_I(rst), .SFR_ADDR_I(adr), .SFR_WDATA_I(wd), .SFR_WR_I(wr), .SFR_RD_I(rd),
		.SFR_RDATA_O(rdat), .GUARD_RST_O(wres), .SYS_RESET_N_O(sysn));
	initial forever #5 clk = ~clk;
	task chk(input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: %h vs %h", $time, s, e);
		end
	endtask
	// Both access tasks start and end at a rising edge, one-cycle strobes
	task w(input logic [7:0] a, d);
		{adr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task r(input logic [7:0] a);
		{adr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		q = rdat;
		@(posedge clk);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task t_key;
		logic [7:0] v [5] = '{8'h55, 8'haa, 8'h54, 8'hd5, 8'h00};
		r(8'hae);
		chk(q, 8'h00);
		chk({wres, sysn}, 8'h01);
		foreach (v[i]) begin
			w(8'hae, v[i]);
			r(8'hae);
			chk(q, v[i]);
		end
		$display("key test end");
	endtask
	task t_map;
		w(8'ha6, 8'h7e);
		r(8'ha6);
		chk(q, 8'h00);
		repeat (100) @(posedge clk);
		w(8'ha6, 8'h00);
		r(8'h00);
		chk(q, 8'h00);
		repeat (200) @(posedge clk);
		chk({wres, sysn}, 8'h01);
		$display("map test end");
	endtask
	task t_ovf;
		int n;
		w(8'ha6, 8'h7e);
		repeat (170) @(posedge clk);
		chk({wres, sysn}, 8'h01);
		n = 0;
		while (wres !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk({wres, sysn}, 8'h02);
		n = 0;
		while (wres === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'd20);
		chk({wres, sysn}, 8'h01);
		@(posedge clk);
		r(8'hae);
		chk(q, 8'h00);
		w(8'hae, 8'h55);
		w(8'ha6, 8'h7e);
		repeat (400) @(posedge clk);
		chk({wres, sysn}, 8'h01);
		w(8'hae, 8'h00);
		repeat (400) @(posedge clk);
		chk({wres, sysn}, 8'h01);
		$display("overflow test end");
	endtask
	task t_rerun;
		w(8'hae, 8'h55);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		r(8'hae);
		chk(q, 8'h00);
		chk({wres, sysn}, 8'h01);
		$display("rerun test end");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_key;
		t_map;
		t_ovf;
		t_rerun;
		summarize;
	end
	initial begin
		#60000;
		error_cnt++;
		summarize;
	end
endmodule // test_watchdog_timer_unit
`default_nettype wire
